/* rtl/hie_regs.svh */
`ifndef HIE_REGS_SVH
`define HIE_REGS_SVH

// Register offsets
`define HIE_REVISION_ID_OFS       8'h00
`define HIE_MAIN_EVENT_FLAGS_OFS  8'h03
`define HIE_WARNING_DIAG_OFS      8'h04
`define HIE_SEQUENCE_DIAG_OFS     8'h05
`define HIE_LIVE_STATUS_OFS       8'h06
`define HIE_EVENT_MASK_OFS        8'h07

// Revision fields
`define HIE_REV_MINOR_MSB         7
`define HIE_REV_MINOR_LSB         4
`define HIE_REV_MAJOR_MSB         3
`define HIE_REV_MAJOR_LSB         0

// Main event, live status and mask bit positions
`define HIE_BIT_OVERCURRENT       7
`define HIE_BIT_MOTOR_FAULT       6
`define HIE_BIT_WARNING           5
`define HIE_BIT_SEQ_FAULT         4
`define HIE_BIT_CRITICAL_HEAT     3
`define HIE_BIT_PLAYBACK_DONE     2
`define HIE_BIT_UNDERVOLTAGE      1
`define HIE_BIT_CHAINED           0

// Warning diagnostic bit positions
`define HIE_BIT_DRIVE_LIMITED     7
`define HIE_BIT_BOOST_LIMITED     6
`define HIE_BIT_MEM_TYPE          4
`define HIE_BIT_HEAT_WARNING      3

// Sequence diagnostic bit positions
`define HIE_BIT_BAD_SEQ_NUMBER    7
`define HIE_BIT_MEM_FAULT         6
`define HIE_BIT_PWM_FAULT         5

// Implemented-bit masks
`define HIE_WARN_DIAG_USED        8'hD8
`define HIE_SEQ_DIAG_USED         8'hE0

// Reset values
`define HIE_MAIN_EVENT_RST        8'h00
`define HIE_DIAG_RST              8'h00
`define HIE_LIVE_STATUS_RST       8'h00
`define HIE_EVENT_MASK_RST        8'h00
`define HIE_READ_DATA_RST         8'h00

`endif

/* rtl/hie_pkg.sv */
`default_nettype none

package hie_pkg;

    // Condition lines from the detectors, one per main event source except the warning and sequence fault summaries
    typedef struct packed {
        logic overcurrent;
        logic motor_fault;
        logic critical_heat;
        logic playback_done;
        logic undervoltage;
        logic chained_playback;
    } hie_event_t;

    // Warning detector lines
    typedef struct packed {
        logic drive_limited_warning;
        logic boost_limited_warning;
        logic mem_type_mismatch;
        logic heat_warning;
    } hie_warning_t;

    // Sequence fault detector lines
    typedef struct packed {
        logic bad_sequence_number_fault;
        logic mem_corrupt_fault;
        logic pwm_timeout_fault;
    } hie_seq_fault_t;

    // Register access from the serial control port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hie_reg_req_t;

    typedef enum logic [1:0] {
        HIE_FLAG_IDLE    = 2'b00,
        HIE_FLAG_PENDING = 2'b01
    } hie_flag_state_t;

endpackage

`default_nettype wire

/* rtl/hie_sticky_bit.sv */
`timescale 1ns/1ps
`default_nettype none

`include "hie_regs.svh"

module hie_sticky_bit
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    input  wire logic set_in,
    input  wire logic clear_in,
    output var  logic flag
);

    // Set wins over clear in the same cycle
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            flag <= 1'b0;
        else if (clk_en)
        begin
            if (set_in)
                flag <= 1'b1;
            else if (clear_in)
                flag <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* rtl/haptic_irq_event_status.sv */
`timescale 1ns/1ps
`default_nettype none

`include "hie_regs.svh"

module haptic_irq_event_status
#(
    parameter logic [3:0] REVISION_MINOR = 4'h1, // Arbitrary value
    parameter logic [3:0] REVISION_MAJOR = 4'h1  // Arbitrary value
)
(
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    clk_en,
    input  wire hie_pkg::hie_reg_req_t   reg_req,
    output var  logic [7:0]              reg_rdata,
    input  wire hie_pkg::hie_event_t     event_in,
    input  wire hie_pkg::hie_warning_t   warning_in,
    input  wire hie_pkg::hie_seq_fault_t seq_fault_in,
    input  wire logic                    mem_data_signed,
    input  wire logic                    acceleration_en,
    output var  logic                    irq_out,
    output var  logic                    supply_lockout
);

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    logic [7:0] event_flags;
    logic [7:0] warn_diag;
    logic [7:0] seq_diag;
    logic [7:0] event_mask;
    logic [7:0] live_status;
    logic [7:0] event_set;
    logic [7:0] event_clear;
    logic       warn_clear;
    logic       seq_clear;
    logic [7:0] warn_set;
    logic [7:0] seq_set;
    logic       mem_type_mismatch;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    always_comb
    begin
        event_clear = 8'h00;
        if (reg_req.wr && hit(reg_req.addr, `HIE_MAIN_EVENT_FLAGS_OFS))
            event_clear = reg_req.wdata;
    end

    assign warn_clear = event_clear[`HIE_BIT_WARNING];
    assign seq_clear  = event_clear[`HIE_BIT_SEQ_FAULT];

    // ------------------------------------------------------------
    // Diagnostic sources
    // ------------------------------------------------------------
    assign mem_type_mismatch = (mem_data_signed != acceleration_en)
                               || warning_in.mem_type_mismatch;

    always_comb
    begin
        warn_set = 8'h00;
        warn_set[`HIE_BIT_DRIVE_LIMITED] = warning_in.drive_limited_warning;
        warn_set[`HIE_BIT_BOOST_LIMITED] = warning_in.boost_limited_warning;
        warn_set[`HIE_BIT_MEM_TYPE]      = mem_type_mismatch;
        warn_set[`HIE_BIT_HEAT_WARNING]  = warning_in.heat_warning;
    end

    always_comb
    begin
        seq_set = 8'h00;
        seq_set[`HIE_BIT_BAD_SEQ_NUMBER] = seq_fault_in.bad_sequence_number_fault;
        seq_set[`HIE_BIT_MEM_FAULT]      = seq_fault_in.mem_corrupt_fault;
        seq_set[`HIE_BIT_PWM_FAULT]      = seq_fault_in.pwm_timeout_fault;
    end

    // ------------------------------------------------------------
    // Main event sources
    // ------------------------------------------------------------
    always_comb
    begin
        event_set = 8'h00;
        event_set[`HIE_BIT_OVERCURRENT]   = event_in.overcurrent;
        event_set[`HIE_BIT_MOTOR_FAULT]   = event_in.motor_fault;
        event_set[`HIE_BIT_WARNING]       = |warn_set;
        event_set[`HIE_BIT_SEQ_FAULT]     = |seq_set;
        event_set[`HIE_BIT_CRITICAL_HEAT] = event_in.critical_heat;
        event_set[`HIE_BIT_PLAYBACK_DONE] = event_in.playback_done;
        event_set[`HIE_BIT_UNDERVOLTAGE]  = event_in.undervoltage;
        event_set[`HIE_BIT_CHAINED]       = event_in.chained_playback;
    end

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_flags
            hie_sticky_bit u_event
            (
                .clk      (clk),
                .reset_n  (reset_n),
                .clk_en   (clk_en),
                .set_in   (event_set[gi]),
                .clear_in (event_clear[gi]),
                .flag     (event_flags[gi])
            );
        end
    endgenerate

    // Diagnostics: set wins, cleared only through their summary bit
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            warn_diag <= `HIE_DIAG_RST;
        else if (clk_en)
            warn_diag <= (warn_diag & ~{8{warn_clear}}) | warn_set;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            seq_diag <= `HIE_DIAG_RST;
        else if (clk_en)
            seq_diag <= (seq_diag & ~{8{seq_clear}}) | seq_set;
    end

    // ------------------------------------------------------------
    // Live status and mask
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            live_status <= `HIE_LIVE_STATUS_RST;
        else if (clk_en)
            live_status <= event_set;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            event_mask <= `HIE_EVENT_MASK_RST;
        else if (clk_en && reg_req.wr && hit(reg_req.addr, `HIE_EVENT_MASK_OFS))
            event_mask <= reg_req.wdata;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Summary bits stay raised while any diagnostic is held
    logic [7:0] event_view;

    always_comb
    begin
        event_view = event_flags;
        event_view[`HIE_BIT_WARNING]   = event_flags[`HIE_BIT_WARNING] | (|warn_diag);
        event_view[`HIE_BIT_SEQ_FAULT] = event_flags[`HIE_BIT_SEQ_FAULT] | (|seq_diag);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_out <= 1'b0;
        else if (clk_en)
            irq_out <= |(event_view & ~event_mask);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            supply_lockout <= 1'b0;
        else if (clk_en)
            supply_lockout <= event_view[`HIE_BIT_UNDERVOLTAGE];
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= `HIE_READ_DATA_RST;
        else if (clk_en && reg_req.rd)
        begin
            unique case (reg_req.addr)
                `HIE_REVISION_ID_OFS:      reg_rdata <= {REVISION_MINOR, REVISION_MAJOR};
                `HIE_MAIN_EVENT_FLAGS_OFS: reg_rdata <= event_view;
                `HIE_WARNING_DIAG_OFS:     reg_rdata <= warn_diag & `HIE_WARN_DIAG_USED;
                `HIE_SEQUENCE_DIAG_OFS:    reg_rdata <= seq_diag & `HIE_SEQ_DIAG_USED;
                `HIE_LIVE_STATUS_OFS:      reg_rdata <= live_status;
                `HIE_EVENT_MASK_OFS:       reg_rdata <= event_mask;
                default:                   reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

`default_nettype wire

/* tb/haptic_irq_event_status_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ------
// Checker
// ------
module hie_checker
#(
    parameter logic [3:0] REVISION_MINOR = 4'h0,
    parameter logic [3:0] REVISION_MAJOR = 4'h0
)
(
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    clk_en,
    input  wire hie_pkg::hie_reg_req_t   reg_req,
    input  wire logic [7:0]              reg_rdata,
    input  wire hie_pkg::hie_event_t     event_in,
    input  wire hie_pkg::hie_seq_fault_t seq_fault_in,
    input  wire logic                    irq_out,
    input  wire logic                    supply_lockout
);
    logic [7:0] mask_q;
    logic       up;
    logic       rd_en;
    logic       clr_uv;
    logic [6:0] live_exp;
    assign rd_en = clk_en && reg_req.rd;
    assign clr_uv = clk_en && reg_req.wr && reg_req.addr == 8'h03 && reg_req.wdata[1];
    assign live_exp = {event_in[5:4], |seq_fault_in, event_in[3:0]};
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            up <= 1'b0;
        else
            up <= 1'b1;
    // Shadow of the mask register
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            mask_q <= 8'h00;
        else if (clk_en && reg_req.wr && reg_req.addr == 8'h07)
            mask_q <= reg_req.wdata;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_REV_READ:
        assert property (rd_en && reg_req.addr == 8'h00 |=> reg_rdata == {REVISION_MINOR, REVISION_MAJOR})
        else $error("revision readout wrong");
    AST_LIVE_READ:
        assert property (up && $past(clk_en) && rd_en && reg_req.addr == 8'h06
            |=> {reg_rdata[7:6], reg_rdata[4:0]} == $past(live_exp, 2))
        else $error("live status readout wrong");
    AST_MASK_READ:
        assert property (rd_en && reg_req.addr == 8'h07 |=> reg_rdata == $past(mask_q))
        else $error("mask readout wrong");
    AST_IRQ_RAISE:
        assert property ((clk_en && event_in.overcurrent && !mask_q[7]) ##1 (clk_en && !mask_q[7])
            |=> irq_out)
        else $error("unmasked event gave no interrupt");
    AST_IRQ_QUIET:
        assert property ((clk_en && mask_q == 8'hFF)[*2] |=> !irq_out)
        else $error("interrupt while all masked");
    AST_UV_SET:
        assert property (clk_en && event_in.undervoltage |-> ##[1:2] supply_lockout)
        else $error("lockout not raised");
    AST_UV_HOLD:
        assert property (supply_lockout && !clr_uv && !$past(clr_uv) |=> supply_lockout)
        else $error("lockout dropped without clear");
    AST_UV_CLEAR:
        assert property (clr_uv && !event_in.undervoltage |-> ##[1:2] !supply_lockout)
        else $error("lockout not cleared");
endmodule
`default_nettype wire

/* tb/hie_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------
// Host on the control port
// ------
module hie_host_model
(
    input  wire logic                  clk,
    input  wire logic [7:0]            reg_rdata,
    output var  hie_pkg::hie_reg_req_t reg_req
);
    initial reg_req = '0;
    // Released address and data show the inverse, never the last value
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clk);
        reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        #1 q = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* tb/haptic_irq_event_status_test.sv */
`timescale 1ns/1ps
`default_nettype none
module haptic_irq_event_status_test;
    logic                    clk;
    logic                    reset_n;
    logic                    clk_en;
    logic                    irq_out;
    logic                    supply_lockout;
    logic [1:0]              sa;
    logic [7:0]              reg_rdata;
    logic [7:0]              q;
    hie_pkg::hie_reg_req_t   reg_req;
    hie_pkg::hie_event_t     ev;
    hie_pkg::hie_warning_t   wa;
    hie_pkg::hie_seq_fault_t sf;
    int                      n_errors = 0;
    int                      checks = 0;
    haptic_irq_event_status #(.REVISION_MINOR(4'h3), .REVISION_MAJOR(4'h5))
    haptic_irq_event_status_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .event_in(ev), .warning_in(wa),
        .seq_fault_in(sf), .mem_data_signed(sa[1]), .acceleration_en(sa[0]),
        .irq_out(irq_out), .supply_lockout(supply_lockout));
    hie_host_model hie_host_model_inst (.clk(clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
    // ------
    // Helpers
    // ------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        hie_host_model_inst.access(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        hie_host_model_inst.access(1'b1, a, d, q);
    endtask
    task automatic irq_is(input logic v);
        for (int i = 0; i < 4 && irq_out !== v; i++)
            @(posedge clk);
        #1 chk({7'h00, irq_out}, {7'h00, v});
        // Bound used up: stop here
        if (irq_out !== v)
            tally_and_finish();
    endtask
    task automatic pulse(input logic [5:0] e, input logic [3:0] w, input logic [2:0] s,
                         input logic [1:0] m);
        @(posedge clk);
        ev <= e;
        wa <= w;
        sf <= s;
        sa <= m;
        @(posedge clk);
        ev <= '0;
        wa <= '0;
        sf <= '0;
        sa <= 2'b00;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ------
    // Scenarios
    // ------
    task automatic t_reset;
        rd(8'h00, 8'h35);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h35);
        rd(8'h07, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h01, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_events;
        logic [7:0] rb [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40, 8'h80};
        for (int i = 0; i < 6; i++)
        begin
            pulse(6'h01 << i, 4'h0, 3'h0, 2'b00);
            irq_is(1'b1);
            rd(8'h03, rb[i]);
            wr(8'h03, rb[i]);
            rd(8'h03, 8'h00);
            irq_is(1'b0);
        end
        $display("event test done");
    endtask
    task automatic t_diag;
        logic [8:0] st [9] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h002, 9'h001, 9'h010,
                               9'h008, 9'h004};
        logic [7:0] dv [9] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h10, 8'h10, 8'h80, 8'h40, 8'h20};
        logic [7:0] ad;
        logic [7:0] sb;
        for (int i = 0; i < 9; i++)
        begin
            ad = (i < 6) ? 8'h04 : 8'h05;
            sb = (i < 6) ? 8'h20 : 8'h10;
            pulse(6'h00, st[i][8:5], st[i][4:2], st[i][1:0]);
            rd(8'h03, sb);
            wr(ad, 8'hFF);
            wr(8'h03, ~sb);
            rd(ad, dv[i]);
            wr(8'h03, sb);
            rd(ad, 8'h00);
            rd(8'h03, 8'h00);
        end
        $display("diagnostic test done");
    endtask
    task automatic t_live;
        @(posedge clk);
        ev <= 6'h3F;
        wa <= 4'h1;
        sf <= 3'h1;
        rd(8'h06, 8'hFF);
        wr(8'h03, 8'hA2);
        rd(8'h03, 8'hFF);
        chk({7'h00, supply_lockout}, 8'h01);
        pulse(6'h00, 4'h0, 3'h0, 2'b00);
        rd(8'h06, 8'h00);
        wr(8'h03, 8'hFF);
        rd(8'h03, 8'h00);
        chk({7'h00, supply_lockout}, 8'h00);
        irq_is(1'b0);
        $display("live status test done");
    endtask
    task automatic t_mask;
        wr(8'h07, 8'hFF);
        rd(8'h07, 8'hFF);
        pulse(6'h20, 4'h0, 3'h0, 2'b00);
        repeat (3) @(posedge clk);
        #1 chk({7'h00, irq_out}, 8'h00);
        rd(8'h03, 8'h80);
        wr(8'h07, 8'h7F);
        irq_is(1'b1);
        wr(8'h03, 8'h80);
        irq_is(1'b0);
        $display("mask test done");
    endtask
    task automatic t_freeze;
        pulse(6'h20, 4'h0, 3'h0, 2'b00);
        @(posedge clk);
        clk_en <= 1'b0;
        wr(8'h03, 8'h80);
        @(posedge clk);
        clk_en <= 1'b1;
        rd(8'h03, 8'h80);
        wr(8'h03, 8'h80);
        rd(8'h03, 8'h00);
        irq_is(1'b0);
        $display("clock enable test done");
    endtask
    task automatic t_rereset;
        pulse(6'h20, 4'h0, 3'h0, 2'b00);
        irq_is(1'b1);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h03, 8'h00);
        rd(8'h07, 8'h00);
        irq_is(1'b0);
        $display("mid-run reset test done");
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        ev = '0;
        wa = '0;
        sf = '0;
        sa = 2'b00;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_events();
        t_diag();
        t_live();
        t_freeze();
        t_mask();
        t_rereset();
        tally_and_finish();
    end
endmodule
bind haptic_irq_event_status hie_checker #(.REVISION_MINOR(REVISION_MINOR),
    .REVISION_MAJOR(REVISION_MAJOR)) hie_checker_inst (.clk(clk), .reset_n(reset_n),
    .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata), .event_in(event_in),
    .seq_fault_in(seq_fault_in), .irq_out(irq_out), .supply_lockout(supply_lockout));
`default_nettype wire
